//--- src/bem_cfg.svh
// constants for the bridge error monitor
`ifndef BEM_CFG_SVH
`define BEM_CFG_SVH
`define BEM_CODE_RBUF 16'h1020
`define BEM_CODE_PTS 16'h1021
`define BEM_CODE_MODE_BAD 16'h1022
`define BEM_CODE_IP_CHG 16'h1030
`define BEM_CODE_SW_BASE 16'h1040
`define BEM_CODE_HIST_LIM 16'h1050
`define BEM_CODE_IP_LIM 16'h1051
`define BEM_CODE_PAR_LIM 16'h1052
`define BEM_CODE_NVM_ERR 16'h1060
`define BEM_CODE_NONE 16'h0000
`define BEM_ADDR_STATUS 4'h0
`define BEM_ADDR_MASK 4'h1
`define BEM_ADDR_CODE 4'h2
`define BEM_ADDR_CTRL 4'h3
`define BEM_ADDR_COUNT 4'h4
`define BEM_ADDR_SEV 4'h5
`define BEM_MASK_RESET 16'h0000
`define BEM_BLINK_NS 250000000
`define BEM_CLK_NS 100
`define BEM_BLINK_CYC (`BEM_BLINK_NS / `BEM_CLK_NS)
`define BEM_SAVE_MAX 16'h0100
`define BEM_IRQ_BITS 9
`endif

//--- src/bem_pkg.sv
// types for the bridge error monitor
package bem_pkg;
	typedef enum logic [1:0] {
		BEM_SEV_NONE = 2'h0,
		BEM_SEV_MINOR = 2'h1,
		BEM_SEV_MODERATE = 2'h3,
		BEM_SEV_MAJOR = 2'h2
	} bem_sev_e;
endpackage : bem_pkg

//--- src/bem_blinker.sv
// square wave for the flashing error lamp
`timescale 1ns/1ps
`include "bem_cfg.svh"
module bem_blinker #(
	parameter int HALF_CYC = `BEM_BLINK_CYC
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// wave
	output logic wave_out
);
	logic [31:0] cnt_reg;
	wire logic wrap = (cnt_reg >= 32'(HALF_CYC - 1));
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_reg <= 32'h0;
			wave_out <= 1'b0;
		end else begin
			cnt_reg <= wrap ? 32'h0 : cnt_reg + 32'h1;
			if (wrap) wave_out <= ~wave_out;
		end
	end
endmodule : bem_blinker

//--- src/bem_save_limit.sv
// write-count limiter for one non-volatile storage area
`timescale 1ns/1ps
`include "bem_cfg.svh"
module bem_save_limit #(
	parameter logic [15:0] MAX_SAVES = `BEM_SAVE_MAX
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// request side
	input wire logic save_req_in,
	output logic save_go_out,
	output logic limit_out,
	output logic [15:0] count_out
);
	wire logic at_max = (count_out >= MAX_SAVES);
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_out <= 16'h0;
			save_go_out <= 1'b0;
			limit_out <= 1'b0;
		end else begin
			save_go_out <= save_req_in && !at_max;
			if (save_req_in && !at_max) count_out <= count_out + 16'h1;
			limit_out <= at_max;
		end
	end
endmodule : bem_save_limit

//--- src/bem_monitor.sv
// error detection, classification, lamps and register port of the bridge
//
// Contract
// - major error: run lamp off, field transmission halted, unrecoverable
// - moderate error: error lamp steady on, field transmission halted
// - minor error: keep running, error lamp flashes
// - remote message send outside remote buffer raises 1020H
// - tool points setting while field points setting enabled raises 1021H
// - forbidden mode switch combination raises 1022H until power cycle
// - IP selector differing from power-on position raises 1030H
// - mode switch n differing from power-on position raises 1040H plus n
// - error history save limit raises 1050H and stops history saves
// - IP address save limit raises 1051H and blocks IP saves
// - parameter save limit raises 1052H and blocks parameter saves
// - host error clear request clears pending errors
// - non-volatile access failure during history save raises 1060H
`timescale 1ns/1ps
`include "bem_cfg.svh"
module bem_monitor #(
	parameter int NUM_SW = 12,
	parameter int IP_W = 8,
	parameter logic [15:0] RBUF_SIZE = 16'h0800,
	parameter int BLINK_CYC = `BEM_BLINK_CYC,
	parameter logic [15:0] HIST_MAX = `BEM_SAVE_MAX,
	parameter logic [15:0] IP_MAX = `BEM_SAVE_MAX,
	parameter logic [15:0] PAR_MAX = `BEM_SAVE_MAX
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// fault sources
	input wire logic major_fault_in,
	input wire logic moderate_fault_in,
	input wire logic rmsg_req_in,
	input wire logic [15:0] rmsg_addr_in,
	input wire logic [15:0] rmsg_len_in,
	input wire logic tool_pts_set_in,
	input wire logic field_pts_en_in,
	input wire logic [NUM_SW-1:0] mode_sw_in,
	input wire logic [IP_W-1:0] ip_sw_in,
	input wire logic mode_forbidden_in,
	// non-volatile save requests
	input wire logic hist_save_req_in,
	input wire logic hist_nvm_fail_in,
	input wire logic ip_save_req_in,
	input wire logic par_save_req_in,
	output logic hist_save_go_out,
	output logic ip_save_go_out,
	output logic par_save_go_out,
	// lamps, line and interrupt
	output logic run_led_out,
	output logic err_led_out,
	output logic field_tx_en_out,
	output logic irq_out
);
	// status bits: 0 rbuf,1 pts,2 mode bad,3 ip chg,4 sw chg,5 hist,6 ip lim,7 par lim,8 nvm
	logic captured_reg;
	logic [NUM_SW-1:0] sw_cap_reg;
	logic [IP_W-1:0] ip_cap_reg;
	logic [NUM_SW-1:0] sw_err_reg;
	logic [`BEM_IRQ_BITS-1:0] stat_reg;
	logic [`BEM_IRQ_BITS-1:0] stat_next;
	logic [`BEM_IRQ_BITS-1:0] mask_reg;
	logic mode_bad_reg;
	logic major_reg;
	logic moderate_reg;
	logic [15:0] code_reg;
	logic [15:0] code_next;
	logic blink;
	logic hist_lim;
	logic ip_lim;
	logic par_lim;
	logic hist_go;
	logic ip_go;
	logic par_go;
	logic [15:0] hist_cnt;
	bem_pkg::bem_sev_e sev;

	// register decode
	wire logic wr_status = reg_wr_in && (reg_addr_in == `BEM_ADDR_STATUS);
	wire logic wr_mask = reg_wr_in && (reg_addr_in == `BEM_ADDR_MASK);
	wire logic wr_ctrl = reg_wr_in && (reg_addr_in == `BEM_ADDR_CTRL);
	// ctrl bit 0 is the host error clear request
	wire logic clr_req = wr_ctrl && reg_wdata_in[0];

	// event detection
	wire logic [16:0] rmsg_end = {1'b0, rmsg_addr_in} + {1'b0, rmsg_len_in};
	wire logic ev_rbuf = rmsg_req_in && (rmsg_end > {1'b0, RBUF_SIZE});
	wire logic ev_pts = tool_pts_set_in && field_pts_en_in;
	wire logic [NUM_SW-1:0] sw_diff = captured_reg ? (mode_sw_in ^ sw_cap_reg) : '0;
	wire logic ip_diff = captured_reg && (ip_sw_in != ip_cap_reg);
	wire logic ev_sw = |sw_diff;
	wire logic ev_nvm = hist_go && hist_nvm_fail_in;

	wire logic [`BEM_IRQ_BITS-1:0] events = {ev_nvm, par_lim, ip_lim, hist_lim, ev_sw,
		ip_diff, mode_bad_reg, ev_pts, ev_rbuf};
	// mode-bad is held until power cycle, so a clear cannot drop it
	wire logic [`BEM_IRQ_BITS-1:0] w1c = wr_status ? reg_wdata_in[`BEM_IRQ_BITS-1:0] : '0;
	wire logic [`BEM_IRQ_BITS-1:0] clr_bits = clr_req ? '1 : w1c;
	assign stat_next = (stat_reg & ~clr_bits) | events;

	wire logic minor_any = |stat_reg;
	assign sev = major_reg ? bem_pkg::BEM_SEV_MAJOR :
		moderate_reg ? bem_pkg::BEM_SEV_MODERATE :
		minor_any ? bem_pkg::BEM_SEV_MINOR : bem_pkg::BEM_SEV_NONE;

	// latest code, lowest bit number wins within one cycle
	always_comb begin
		code_next = code_reg;
		if (clr_req) code_next = `BEM_CODE_NONE;
		if (ev_nvm) code_next = `BEM_CODE_NVM_ERR;
		if (par_lim && !stat_reg[7]) code_next = `BEM_CODE_PAR_LIM;
		if (ip_lim && !stat_reg[6]) code_next = `BEM_CODE_IP_LIM;
		if (hist_lim && !stat_reg[5]) code_next = `BEM_CODE_HIST_LIM;
		for (int i = NUM_SW - 1; i >= 0; i--) begin
			if (sw_diff[i] && !sw_err_reg[i]) code_next = `BEM_CODE_SW_BASE + 16'(i + 1);
		end
		if (ip_diff && !stat_reg[3]) code_next = `BEM_CODE_IP_CHG;
		if (mode_bad_reg && !stat_reg[2]) code_next = `BEM_CODE_MODE_BAD;
		if (ev_pts) code_next = `BEM_CODE_PTS;
		if (ev_rbuf) code_next = `BEM_CODE_RBUF;
	end

	// power-on capture of switches
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			captured_reg <= 1'b0;
			sw_cap_reg <= '0;
			ip_cap_reg <= '0;
			mode_bad_reg <= 1'b0;
		end else if (!captured_reg) begin
			captured_reg <= 1'b1;
			sw_cap_reg <= mode_sw_in;
			ip_cap_reg <= ip_sw_in;
			mode_bad_reg <= mode_forbidden_in;
		end
	end

	// fault latches and status
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stat_reg <= '0;
			mask_reg <= '0;
			sw_err_reg <= '0;
			major_reg <= 1'b0;
			moderate_reg <= 1'b0;
			code_reg <= `BEM_CODE_NONE;
		end else begin
			stat_reg <= stat_next;
			code_reg <= code_next;
			sw_err_reg <= clr_req ? sw_diff : (sw_err_reg | sw_diff);
			if (wr_mask) mask_reg <= reg_wdata_in[`BEM_IRQ_BITS-1:0];
			major_reg <= major_reg | major_fault_in;
			moderate_reg <= (moderate_reg & ~clr_req) | moderate_fault_in;
		end
	end

	wire logic [15:0] rd_mux =
		(reg_addr_in == `BEM_ADDR_STATUS) ? 16'(stat_reg) :
		(reg_addr_in == `BEM_ADDR_MASK) ? 16'(mask_reg) :
		(reg_addr_in == `BEM_ADDR_CODE) ? code_reg :
		(reg_addr_in == `BEM_ADDR_COUNT) ? hist_cnt :
		(reg_addr_in == `BEM_ADDR_SEV) ? {14'h0, sev} : 16'h0;

	// lamps, transmission and interrupt, all registered
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			run_led_out <= 1'b0;
			err_led_out <= 1'b0;
			field_tx_en_out <= 1'b0;
			irq_out <= 1'b0;
			reg_rdata_out <= 16'h0;
		end else begin
			run_led_out <= (sev != bem_pkg::BEM_SEV_MAJOR);
			field_tx_en_out <= (sev == bem_pkg::BEM_SEV_MINOR) || (sev == bem_pkg::BEM_SEV_NONE);
			case (sev)
				bem_pkg::BEM_SEV_MAJOR: err_led_out <= 1'b0;
				bem_pkg::BEM_SEV_MODERATE: err_led_out <= 1'b1;
				bem_pkg::BEM_SEV_MINOR: err_led_out <= blink;
				default: err_led_out <= 1'b0;
			endcase
			irq_out <= |(stat_next & mask_reg);
			reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0;
		end
	end

	bem_blinker #(.HALF_CYC(BLINK_CYC)) u_blink (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.wave_out(blink)
	);

	bem_save_limit #(.MAX_SAVES(HIST_MAX)) u_hist (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.save_req_in(hist_save_req_in),
		.save_go_out(hist_go),
		.limit_out(hist_lim),
		.count_out(hist_cnt)
	);
	bem_save_limit #(.MAX_SAVES(IP_MAX)) u_ip (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.save_req_in(ip_save_req_in),
		.save_go_out(ip_go),
		.limit_out(ip_lim),
		.count_out()
	);
	bem_save_limit #(.MAX_SAVES(PAR_MAX)) u_par (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.save_req_in(par_save_req_in),
		.save_go_out(par_go),
		.limit_out(par_lim),
		.count_out()
	);
	assign hist_save_go_out = hist_go;
	assign ip_save_go_out = ip_go;
	assign par_save_go_out = par_go;

	sequence s_rbuf_bad;
		rmsg_req_in && (rmsg_end > {1'b0, RBUF_SIZE});
	endsequence
	AST_RBUF_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_rbuf_bad |=> stat_reg[0] && code_reg == `BEM_CODE_RBUF) else $error("rbuf flag");
	AST_PTS_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		tool_pts_set_in && field_pts_en_in |=> stat_reg[1]) else $error("pts flag");
	AST_MODE_HELD: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		mode_bad_reg |=> mode_bad_reg && stat_reg[2]) else $error("mode bad lost");
	AST_IP_CHG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		captured_reg && ip_sw_in != ip_cap_reg |=> stat_reg[3]) else $error("ip change");
	AST_SW_CHG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		captured_reg && (mode_sw_in != sw_cap_reg) |=> stat_reg[4]) else $error("sw change");
	AST_HIST_STOP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		hist_lim |=> !hist_save_go_out) else $error("history save past limit");
	AST_MAJOR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		major_fault_in |=> ##1 !run_led_out && !field_tx_en_out) else $error("major");
	AST_MODERATE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		moderate_fault_in && !major_reg && !major_fault_in |=> ##1 err_led_out && !field_tx_en_out)
		else $error("moderate");
	AST_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		clr_req && events == '0 |=> stat_reg == '0) else $error("clear");

	// steady-state lamp and line behaviour per latched class, save limits, nvm flag and idle read data
	sequence s_major_latched;
		major_reg;
	endsequence
	sequence s_moderate_only;
		moderate_reg && !major_reg;
	endsequence
	sequence s_nvm_fail;
		hist_save_go_out && hist_nvm_fail_in;
	endsequence
	AST_MAJOR_HELD: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_major_latched |=> major_reg) else $error("major cleared");
	AST_MAJOR_LAMP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_major_latched |=> !run_led_out && !field_tx_en_out) else $error("major lamp");
	AST_MOD_STEADY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_moderate_only |=> err_led_out && !field_tx_en_out) else $error("moderate lamp");
	AST_MINOR_RUNS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		!major_reg && !moderate_reg |=> run_led_out && field_tx_en_out)
		else $error("minor stopped line");
	AST_MINOR_BLINK: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		sev == bem_pkg::BEM_SEV_MINOR |=> err_led_out == $past(blink))
		else $error("minor lamp not flashing");
	AST_IP_STOP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		ip_lim |=> !ip_save_go_out) else $error("ip save past limit");
	AST_PAR_STOP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		par_lim |=> !par_save_go_out) else $error("parameter save past limit");
	AST_NVM_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_nvm_fail |=> stat_reg[8] && code_reg == `BEM_CODE_NVM_ERR)
		else $error("nvm flag");
	AST_MAJOR_SEV: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		s_major_latched |-> sev == bem_pkg::BEM_SEV_MAJOR) else $error("precedence");
	AST_RDATA_IDLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		!reg_rd_in |=> reg_rdata_out == '0) else $error("read data outside read cycle");
endmodule : bem_monitor

//--- verification/bem_host_model.sv
// host side model that drives the register port
`timescale 1ns/1ps
`include "bem_cfg.svh"
module bem_host_model (
	// clock
	input wire logic clk_sys_in,
	// register port
	output logic [3:0] reg_addr_out,
	output logic [15:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	input wire logic [15:0] reg_rdata_in
);
	initial begin
		reg_addr_out = 4'h0;
		reg_wdata_out = 16'h0000;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_out <= 1'b0;
		#1 d = reg_rdata_in;
	endtask : rd
	// error clear request from the host
	task automatic clear_all();
		wr(`BEM_ADDR_CTRL, 16'h0001);
	endtask : clear_all
endmodule : bem_host_model

//--- verification/tb_top.sv
// self-checking bench for the bridge error monitor
`timescale 1ns/1ps
`include "bem_cfg.svh"
module tb_top;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic wr, rd;
	logic [6:0] ev = 7'h00;
	logic field_en = 1'b0, forbid = 1'b0, nvm_fail = 1'b0;
	logic [15:0] ra = 16'h0000, rl = 16'h0000;
	logic [11:0] mode_sw = 12'h000;
	logic [7:0] ip_sw = 8'h00;
	wire [2:0] go;
	logic run_led, err_led, tx_en, irq;
	int go_cnt [3] = '{0, 0, 0};
	int mismatches = 0;
	int total_checks = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		for (int i = 0; i < 3; i++) begin
			if (go[i] === 1'b1) go_cnt[i]++;
		end
	end
	bem_host_model host (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
	bem_monitor #(.BLINK_CYC(4), .HIST_MAX(16'h0002), .IP_MAX(16'h0002), .PAR_MAX(16'h0002)) dut (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.major_fault_in(ev[2]), .moderate_fault_in(ev[3]), .rmsg_req_in(ev[0]),
		.rmsg_addr_in(ra), .rmsg_len_in(rl), .tool_pts_set_in(ev[1]),
		.field_pts_en_in(field_en), .mode_sw_in(mode_sw), .ip_sw_in(ip_sw),
		.mode_forbidden_in(forbid), .hist_save_req_in(ev[4]), .hist_nvm_fail_in(nvm_fail),
		.ip_save_req_in(ev[5]), .par_save_req_in(ev[6]), .hist_save_go_out(go[0]),
		.ip_save_go_out(go[1]), .par_save_go_out(go[2]), .run_led_out(run_led),
		.err_led_out(err_led), .field_tx_en_out(tx_en), .irq_out(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : cyc
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] v;
		host.rd(a, v);
		chk(v, e);
	endtask : rchk
	// one-cycle pulse on event input k
	task automatic pulse(input int k);
		@(posedge clk_sys_in);
		ev <= 7'h01 << k;
		@(posedge clk_sys_in);
		ev <= 7'h00;
		cyc(3);
	endtask : pulse
	task automatic do_reset(input logic f);
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		forbid <= f;
		repeat (5) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		cyc(3);
	endtask : do_reset
	task automatic t_idle();
		chk(run_led, 1'b1);
		chk(tx_en, 1'b1);
		chk(err_led, 1'b0);
		rchk(`BEM_ADDR_MASK, `BEM_MASK_RESET);
		rchk(4'hf, 16'h0000);
	endtask : t_idle
	task automatic t_rbuf();
		int n;
		ra <= 16'h07f0;
		rl <= 16'h0010;
		pulse(0);
		rchk(`BEM_ADDR_STATUS, 16'h0000);
		rl <= 16'h0011;
		pulse(0);
		chk(irq, 1'b0);
		rchk(`BEM_ADDR_STATUS, 16'h0001);
		rchk(`BEM_ADDR_CODE, `BEM_CODE_RBUF);
		rchk(`BEM_ADDR_SEV, 16'h0001);
		host.wr(`BEM_ADDR_MASK, 16'h01ff);
		cyc(2);
		chk(irq, 1'b1);
		n = 0;
		repeat (12) begin
			cyc(1);
			n += err_led;
		end
		chk(16'(n > 2 && n < 10), 16'h0001);
		chk(tx_en, 1'b1);
		host.wr(`BEM_ADDR_STATUS, 16'h0001);
		cyc(2);
		chk(irq, 1'b0);
		rchk(`BEM_ADDR_STATUS, 16'h0000);
	endtask : t_rbuf
	task automatic t_pts();
		pulse(1);
		rchk(`BEM_ADDR_STATUS, 16'h0000);
		field_en <= 1'b1;
		pulse(1);
		rchk(`BEM_ADDR_STATUS, 16'h0002);
		rchk(`BEM_ADDR_CODE, `BEM_CODE_PTS);
		host.wr(`BEM_ADDR_STATUS, 16'h01ff);
	endtask : t_pts
	task automatic t_switch();
		ip_sw <= 8'h01;
		cyc(3);
		rchk(`BEM_ADDR_CODE, `BEM_CODE_IP_CHG);
		ip_sw <= 8'h00;
		cyc(2);
		host.clear_all();
		rchk(`BEM_ADDR_STATUS, 16'h0000);
		for (int n = 1; n <= 12; n++) begin
			mode_sw <= 12'h001 << (n - 1);
			cyc(3);
			rchk(`BEM_ADDR_STATUS, 16'h0010);
			rchk(`BEM_ADDR_CODE, `BEM_CODE_SW_BASE + 16'(n));
			mode_sw <= 12'h000;
			cyc(2);
			host.wr(`BEM_ADDR_STATUS, 16'h01ff);
		end
	endtask : t_switch
	task automatic t_limits();
		for (int k = 0; k < 3; k++) begin
			repeat (3) pulse(4 + k);
			chk(16'(go_cnt[k]), 16'h0002);
			rchk(`BEM_ADDR_CODE, `BEM_CODE_HIST_LIM + 16'(k));
			rchk(`BEM_ADDR_STATUS, (16'h0040 << k) - 16'h0020);
		end
		rchk(`BEM_ADDR_COUNT, 16'h0002);
	endtask : t_limits
	task automatic t_moderate();
		pulse(3);
		repeat (8) begin
			chk(err_led, 1'b1);
			chk(tx_en, 1'b0);
			cyc(1);
		end
		rchk(`BEM_ADDR_SEV, 16'h0003);
		host.clear_all();
		cyc(2);
		chk(tx_en, 1'b1);
		rchk(`BEM_ADDR_SEV, 16'h0001);
	endtask : t_moderate
	task automatic t_forbid_major();
		do_reset(1'b1);
		host.wr(`BEM_ADDR_STATUS, 16'h0004);
		cyc(2);
		rchk(`BEM_ADDR_STATUS, 16'h0004);
		rchk(`BEM_ADDR_CODE, `BEM_CODE_MODE_BAD);
		nvm_fail <= 1'b1;
		pulse(4);
		nvm_fail <= 1'b0;
		rchk(`BEM_ADDR_STATUS, 16'h0104);
		rchk(`BEM_ADDR_CODE, `BEM_CODE_NVM_ERR);
		pulse(3);
		pulse(2);
		chk(run_led, 1'b0);
		rchk(`BEM_ADDR_SEV, 16'h0002);
		host.clear_all();
		cyc(3);
		chk(run_led, 1'b0);
		chk(tx_en, 1'b0);
	endtask : t_forbid_major
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	initial begin
		#(30000 * 100);
		mismatches++;
		complete_run();
	end
	initial begin
		do_reset(1'b0);
		t_idle();
		t_rbuf();
		t_pts();
		t_switch();
		t_limits();
		t_moderate();
		t_forbid_major();
		complete_run();
	end
endmodule : tb_top
